// *** verilog/fasg_consts.vh ***
// Constants for the flash access security guard
`ifndef FASG_CONSTS_VH
`define FASG_CONSTS_VH

// ----------------------------------------------------------------
// Special function register addresses
// ----------------------------------------------------------------
`define FASG_ACL_ADDR 8'hB7
`define FASG_FCR_ADDR 8'hB6

// ----------------------------------------------------------------
// Reset values and control register fields
// ----------------------------------------------------------------
`define FASG_ACL_RESET 8'h00
`define FASG_FCR_RESET 8'h80
`define FASG_FCR_OSE_BIT 7
`define FASG_FCR_RAE_BIT 6
`define FASG_FCR_WEE_BIT 0
`define FASG_FCR_RW_MASK 8'hC1
`define FASG_LOCK_ERASED 8'hFF

// ----------------------------------------------------------------
// Program memory map
// ----------------------------------------------------------------
`define FASG_PAGE_MSB 15
`define FASG_PAGE_LSB 9
`define FASG_RSV_PAGE 7'h7F
`define FASG_SEC_PAGE 7'h7E
`define FASG_WE_LOCK_ADDR 16'hFDFE
`define FASG_RD_LOCK_ADDR 16'hFDFF
`define FASG_BLK_MSB 15
`define FASG_BLK_LSB 13
`define FASG_SEC_BLK 3'h7
`define FASG_LIMIT_LOW 8'h00

// ----------------------------------------------------------------
// Request encodings
// ----------------------------------------------------------------
`define FASG_SRC_CORE 1'b0
`define FASG_SRC_JTAG 1'b1
`define FASG_OP_READ 2'h0
`define FASG_OP_WRITE 2'h1
`define FASG_OP_ERASE 2'h2
`define FASG_OP_FETCH 2'h3

`endif

// *** verilog/fasg_lock_store.v ***
// Shadow copies of the two security lock bytes
`timescale 1ns/1ps
`include "fasg_consts.vh"

module fasg_lock_store (
    input wire clk_sys, // System clock
    input wire nrst, // Asynchronous reset, active low
    input wire [7:0] init_rd_lock, // Read lock byte as stored in flash
    input wire [7:0] init_we_lock, // Write/erase lock byte as stored in flash
    input wire erase_all, // Pulse: lock bytes return to erased state
    input wire wr_en, // Pulse: program one lock byte
    input wire wr_sel_rd, // 1 selects read lock byte, 0 write/erase lock byte
    input wire [7:0] wr_data, // Programmed value
    output reg [7:0] rd_lock, // Read lock byte, registered
    output reg [7:0] we_lock, // Write/erase lock byte, registered
    output reg loaded // High once the bytes have been captured
);

    // ----------------------------------------------------------------
    // Capture after reset release, then follow program and erase
    // ----------------------------------------------------------------
    // Reset holds the most locked value so nothing leaks before capture
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_lock <= 8'h00;
            we_lock <= 8'h00;
            loaded <= 1'b0;
        end else if (!loaded) begin
            rd_lock <= init_rd_lock;
            we_lock <= init_we_lock;
            loaded <= 1'b1;
        end else if (erase_all) begin
            rd_lock <= `FASG_LOCK_ERASED;
            we_lock <= `FASG_LOCK_ERASED;
        end else if (wr_en) begin
            // Flash programming can only clear bits
            if (wr_sel_rd) begin
                rd_lock <= rd_lock & wr_data; // R9
            end else begin
                we_lock <= we_lock & wr_data; // R9
            end
        end
    end

endmodule

// *** verilog/fasg_guard.v ***
// Flash access security guard: access limit, lock bytes, control register
//
// Function
// R1: Limit address is register byte then 0x00
// R2: Upper code cannot touch flash below limit
// R3: Blocked lower read by upper code returns zero
// R4: Lower code reaches both partitions unrestricted
// R5: Upper code may fetch below the limit
// R6: Limit register accepts one write per reset
// R7: Zero limit makes all memory readable
// R8: Software should use 512-byte aligned limits
// R9: Lock bits always readable and clearable
// R10: JTAG erase at security byte erases all
// R11: JTAG erase elsewhere in page erases page
// R12: JTAG obeys locks for read, write, erase
// R13: JTAG may always read security bytes
// R14: JTAG may always write security bytes
// R15: Security page erasable only when unlocked
// R16: Reserved area refused to every requester
// R17: Lock bytes never restrict firmware access
// R18: Firmware cannot erase the security page
// R19: Firmware write/erase needs enable bit set
// R20: Each lock bit governs one 8 KB block
// R21: Page erase sets 512 bytes to 0xFF
// R22: Partition taken from executing address per access
// R23: Control register resets 0x80, reserved read zero
`timescale 1ns/1ps
`include "fasg_consts.vh"

module fasg_guard (
    input wire clk_sys, // System clock, 100 MHz
    input wire nrst, // Asynchronous reset, active low
    input wire [7:0] sfr_addr, // Register address
    input wire sfr_wr, // Register write strobe
    input wire sfr_rd, // Register read strobe
    input wire [7:0] sfr_wdata, // Register write data
    output reg [7:0] sfr_rdata, // Register read data, one cycle after strobe
    input wire req_valid, // Flash access request
    output reg req_ready, // Request may be taken
    input wire req_src, // 0 firmware, 1 JTAG
    input wire [1:0] req_op, // Read, write, erase or fetch
    input wire [15:0] req_addr, // Target flash address
    input wire [15:0] req_pc, // Address of the executing instruction
    input wire [7:0] req_wdata, // Write data
    output reg rsp_valid, // Answer pulse
    output reg rsp_denied, // Access was refused
    output reg [7:0] rsp_rdata, // Read data, zero when refused
    input wire [7:0] init_rd_lock, // Read lock byte held in flash
    input wire [7:0] init_we_lock, // Write/erase lock byte held in flash
    output reg fl_rd, // Flash read pulse
    output reg fl_wr, // Flash byte program pulse
    output reg fl_erase_page, // Flash page erase pulse
    output reg fl_erase_all, // Flash erase of all but reserved area
    output reg [15:0] fl_addr, // Flash address
    output reg [7:0] fl_wdata, // Flash program data
    input wire [7:0] fl_rdata, // Flash read data, valid while fl_rd is high
    output reg sense_amp_oneshot_enable, // Control bit 7
    output reg read_always_enable // Control bit 6
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RESP = 3'b010;
    localparam [2:0] ST_READ = 3'b100;

    reg [2:0] state;
    reg [7:0] access_limit_high_byte;
    reg acl_locked;
    reg [7:0] flash_control_reg;
    wire [15:0] software_read_limit;
    wire [7:0] rd_lock;
    wire [7:0] we_lock;
    wire locks_loaded;
    reg lk_erase_all;
    reg lk_wr;
    reg lk_sel_rd;
    reg [7:0] lk_data;

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    wire acl_hit = (sfr_addr == `FASG_ACL_ADDR);
    wire fcr_hit = (sfr_addr == `FASG_FCR_ADDR);
    wire acl_wr_ok = sfr_wr && acl_hit && !acl_locked;
    wire fcr_wr_ok = sfr_wr && fcr_hit;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // A zero byte gives limit 0x0000, so every pc counts as upper and
    // every address as not below the limit: nothing is hidden. R7
    assign software_read_limit = {access_limit_high_byte, `FASG_LIMIT_LOW}; // R1

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            access_limit_high_byte <= `FASG_ACL_RESET;
            acl_locked <= 1'b0;
            flash_control_reg <= `FASG_FCR_RESET; // R23
        end else begin
            // Later limit writes are dropped until the next reset
            if (acl_wr_ok) begin
                access_limit_high_byte <= sfr_wdata; // R6
                acl_locked <= 1'b1; // R6
            end
            if (fcr_wr_ok) begin
                flash_control_reg <= sfr_wdata & `FASG_FCR_RW_MASK; // R23
            end
        end
    end

    reg [7:0] next_sfr_rdata;

    // Unmapped or idle reads give zero so other sources can be ORed in
    always @* begin
        next_sfr_rdata = 8'h00;
        if (sfr_rd && acl_hit) begin
            next_sfr_rdata = access_limit_high_byte;
        end else if (sfr_rd && fcr_hit) begin
            next_sfr_rdata = flash_control_reg;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
            sense_amp_oneshot_enable <= 1'b1;
            read_always_enable <= 1'b0;
        end else begin
            sense_amp_oneshot_enable <= flash_control_reg[`FASG_FCR_OSE_BIT];
            read_always_enable <= flash_control_reg[`FASG_FCR_RAE_BIT];
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Lock byte shadow
    // ----------------------------------------------------------------
    fasg_lock_store u_locks (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .init_rd_lock(init_rd_lock),
        .init_we_lock(init_we_lock),
        .erase_all(lk_erase_all),
        .wr_en(lk_wr),
        .wr_sel_rd(lk_sel_rd),
        .wr_data(lk_data),
        .rd_lock(rd_lock),
        .we_lock(we_lock),
        .loaded(locks_loaded)
    );

    // ----------------------------------------------------------------
    // Access decision
    // ----------------------------------------------------------------
    wire [6:0] page = req_addr[`FASG_PAGE_MSB:`FASG_PAGE_LSB];
    wire [2:0] blk = req_addr[`FASG_BLK_MSB:`FASG_BLK_LSB];
    wire in_rsv = (page == `FASG_RSV_PAGE);
    wire in_sec_page = (page == `FASG_SEC_PAGE);
    wire at_we_byte = (req_addr == `FASG_WE_LOCK_ADDR);
    wire at_rd_byte = (req_addr == `FASG_RD_LOCK_ADDR);
    wire at_sec_byte = at_we_byte | at_rd_byte;
    // Sampled with each request, so a call into lower code changes rights
    wire pc_upper = (req_pc >= software_read_limit); // R22
    wire below_limit = (req_addr < software_read_limit);
    wire fw_we_on = flash_control_reg[`FASG_FCR_WEE_BIT];

    // ----------------------------------------------------------------
    // Permission terms
    // ----------------------------------------------------------------
    // Upper code loses the lower partition for data, never for fetch
    wire fw_part_ok = !(pc_upper && below_limit); // R2 R4
    wire jtag_rd_ok = at_sec_byte | rd_lock[blk]; // R13 R12 R20
    wire jtag_wr_ok = at_sec_byte | we_lock[blk]; // R14 R12 R20
    wire jtag_pg_ok = in_sec_page ? we_lock[`FASG_SEC_BLK] : we_lock[blk]; // R15 R11 R12
    wire is_erase = (req_op == `FASG_OP_ERASE);
    wire is_write = (req_op == `FASG_OP_WRITE);
    wire lock_page_erase = is_erase && in_sec_page; // R15 R11

    reg allow;
    reg do_erase_all;

    always @* begin
        allow = 1'b0;
        do_erase_all = 1'b0;
        if (in_rsv) begin
            allow = 1'b0; // R16
        end else if (req_src == `FASG_SRC_JTAG) begin
            case (req_op)
                `FASG_OP_READ: begin
                    allow = jtag_rd_ok; // R13 R12 R20
                end
                `FASG_OP_WRITE: begin
                    allow = jtag_wr_ok; // R14 R12 R20
                end
                `FASG_OP_ERASE: begin
                    if (at_sec_byte) begin
                        allow = 1'b1; // R10
                        do_erase_all = 1'b1; // R10
                    end else begin
                        allow = jtag_pg_ok; // R15 R11 R12
                    end
                end
                default: begin
                    allow = 1'b0;
                end
            endcase
        end else begin
            // Firmware never looks at the lock bytes. R17
            case (req_op)
                `FASG_OP_FETCH: begin
                    allow = 1'b1; // R5
                end
                `FASG_OP_READ: begin
                    allow = fw_part_ok; // R2 R4
                end
                `FASG_OP_WRITE: begin
                    allow = fw_we_on && fw_part_ok; // R19 R2 R4
                end
                `FASG_OP_ERASE: begin
                    allow = fw_we_on && !in_sec_page && fw_part_ok; // R19 R18 R2
                end
                default: begin
                    allow = 1'b0;
                end
            endcase
        end
    end

    wire take = req_valid && req_ready;
    wire is_rd = (req_op == `FASG_OP_READ) || (req_op == `FASG_OP_FETCH);

    // ----------------------------------------------------------------
    // Flash and lock commands for an allowed request
    // ----------------------------------------------------------------
    wire go = take && allow;
    wire cmd_erase_page = go && is_erase && !do_erase_all; // R21 R11
    wire cmd_erase_all = go && do_erase_all; // R10
    wire cmd_lock_reset = go && (do_erase_all || lock_page_erase); // R15 R11
    wire cmd_lock_wr = go && is_write && at_sec_byte; // R9 R14

    // ----------------------------------------------------------------
    // Request sequencing and flash commands
    // ----------------------------------------------------------------
    reg [2:0] next_state;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take && allow && is_rd) begin
                    next_state = ST_READ;
                end else if (take) begin
                    next_state = ST_RESP;
                end
            end
            ST_READ: begin
                next_state = ST_RESP;
            end
            ST_RESP: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_denied <= 1'b0;
            rsp_rdata <= 8'h00;
            fl_rd <= 1'b0;
            fl_wr <= 1'b0;
            fl_erase_page <= 1'b0;
            fl_erase_all <= 1'b0;
            fl_addr <= 16'h0000;
            fl_wdata <= 8'h00;
            lk_erase_all <= 1'b0;
            lk_wr <= 1'b0;
            lk_sel_rd <= 1'b0;
            lk_data <= 8'h00;
        end else begin
            state <= next_state;
            req_ready <= (next_state == ST_IDLE) && locks_loaded && !take;
            rsp_valid <= 1'b0;
            fl_rd <= 1'b0;
            fl_wr <= 1'b0;
            fl_erase_page <= 1'b0;
            fl_erase_all <= 1'b0;
            lk_erase_all <= 1'b0;
            lk_wr <= 1'b0;
            if (take) begin
                fl_addr <= req_addr;
                fl_wdata <= req_wdata;
                rsp_denied <= !allow;
                rsp_rdata <= 8'h00; // R3
                if (!allow || !is_rd) begin
                    rsp_valid <= 1'b1;
                end
                if (allow) begin
                    fl_rd <= is_rd;
                    fl_wr <= is_write;
                    // Flash sets the whole page, or all but the reserved area, to 0xFF
                    fl_erase_page <= cmd_erase_page; // R21 R11
                    fl_erase_all <= cmd_erase_all; // R10
                    // Security page erase brings the locks back to open
                    lk_erase_all <= cmd_lock_reset; // R15 R11
                    lk_wr <= cmd_lock_wr; // R9 R14
                    lk_sel_rd <= at_rd_byte;
                    lk_data <= req_wdata;
                end
            end else if (state == ST_READ) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= fl_rdata;
            end
        end
    end

endmodule

// *** test/fasg_flash_model.sv ***
// Behavioural program flash that answers the guard's flash strobes
`timescale 1ns/1ps

module fasg_flash_model (
    input wire clk_sys, // clock
    input wire fl_rd, // read strobe
    input wire fl_wr, // program strobe
    input wire fl_erase_page, // page erase
    input wire fl_erase_all, // full erase
    input wire [15:0] fl_addr, // address
    input wire [7:0] fl_wdata, // program data
    output logic [7:0] fl_rdata // read data
);
    logic [7:0] mem [0:65535];
    logic [7:0] junk = 8'hA5;

    // Data means nothing outside the read strobe, so it churns there
    assign fl_rdata = fl_rd ? mem[fl_addr] : junk;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
        end
    end

    always @(posedge clk_sys) begin
        junk <= junk + 8'h3B;
        if (fl_wr) begin
            mem[fl_addr] <= mem[fl_addr] & fl_wdata;
        end
        if (fl_erase_all || fl_erase_page) begin
            // Reserved area from 0xFE00 up is never erased
            for (int i = 0; i < 65024; i++) begin
                if (fl_erase_all || i[15:9] == fl_addr[15:9]) begin
                    mem[i] <= 8'hFF;
                end
            end
        end
    end
endmodule

// *** test/fasg_guard_chk.sv ***
// Assertion checker for the flash access security guard
`timescale 1ns/1ps
`include "fasg_consts.vh"

module fasg_guard_chk (
    input wire clk_sys, // clock
    input wire nrst, // reset, active low
    input wire [7:0] sfr_addr, // register address
    input wire sfr_wr, // register write
    input wire sfr_rd, // register read
    input wire [7:0] sfr_wdata, // write data
    input wire [7:0] sfr_rdata, // read data
    input wire req_valid, // request
    input wire req_ready, // request ready
    input wire req_src, // requester
    input wire [1:0] req_op, // operation
    input wire [15:0] req_addr, // target
    input wire [15:0] req_pc, // executing address
    input wire rsp_valid, // answer
    input wire rsp_denied, // refused
    input wire [7:0] rsp_rdata, // answer data
    input wire fl_rd, // flash read
    input wire fl_wr, // flash program
    input wire fl_erase_page, // page erase
    input wire fl_erase_all // full erase
);
    logic [7:0] lim_q;
    logic lim_done;
    wire take = req_valid && req_ready;
    wire [15:0] lim_addr = {lim_q, 8'h00};

    // Shadow of the write-once limit, kept from the bus alone
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lim_q <= 8'h00;
            lim_done <= 1'b0;
        end else if (sfr_wr && sfr_addr == `FASG_ACL_ADDR && !lim_done) begin
            lim_q <= sfr_wdata;
            lim_done <= 1'b1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_read_ok;
        fl_rd ##1 (rsp_valid && !rsp_denied);
    endsequence
    sequence s_refused;
        rsp_valid && rsp_denied;
    endsequence

    property p_deny_nodata;
        s_refused |-> rsp_rdata == 8'h00 && !fl_wr && !fl_erase_page && !fl_erase_all;
    endproperty
    a_deny_nodata: assert property (p_deny_nodata) else $error("refused answer carries data");
    property p_rsv;
        take && req_addr >= 16'hFE00 |=> s_refused;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved area not refused");
    property p_sec_read;
        take && req_src && req_op == `FASG_OP_READ && req_addr[15:1] == 15'h7EFF |=> s_read_ok;
    endproperty
    a_sec_read: assert property (p_sec_read) else $error("security byte read refused");
    property p_fetch;
        take && !req_src && req_op == `FASG_OP_FETCH && req_addr < 16'hFE00 |=> s_read_ok;
    endproperty
    a_fetch: assert property (p_fetch) else $error("code fetch refused");
    property p_upper_block;
        take && !req_src && req_op != `FASG_OP_FETCH && req_pc >= lim_addr
            && req_addr < lim_addr |=> s_refused;
    endproperty
    a_upper_block: assert property (p_upper_block) else $error("lower partition reached");
    property p_lim_read;
        sfr_rd && sfr_addr == `FASG_ACL_ADDR |=> sfr_rdata == lim_q;
    endproperty
    a_lim_read: assert property (p_lim_read) else $error("limit register value wrong");
    property p_fw_sec_erase;
        take && !req_src && req_op == `FASG_OP_ERASE && req_addr[15:9] == 7'h7E |=> s_refused;
    endproperty
    a_fw_sec_erase: assert property (p_fw_sec_erase) else $error("firmware erased lock page");
    property p_erase_all;
        take && req_src && req_op == `FASG_OP_ERASE && req_addr[15:1] == 15'h7EFF
            |=> fl_erase_all && rsp_valid && !rsp_denied;
    endproperty
    a_erase_all: assert property (p_erase_all) else $error("full erase not started");
endmodule

bind fasg_guard fasg_guard_chk i_chk (.*);

// *** test/flash_access_security_guard_tb_top.sv ***
// Self-checking testbench for the flash access security guard
`timescale 1ns/1ps
`include "fasg_consts.vh"
`define FASG_CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, ex, got); end end

module flash_access_security_guard_tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, req_wdata = 8'h00;
    logic [7:0] init_rd_lock = 8'hFE, init_we_lock = 8'hFD;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, req_valid = 1'b0, req_src = 1'b0;
    logic [1:0] req_op = 2'h0;
    logic [15:0] req_addr = 16'h0000, req_pc = 16'h0000;
    wire [7:0] sfr_rdata, rsp_rdata, fl_wdata, fl_rdata;
    wire [15:0] fl_addr;
    wire req_ready, rsp_valid, rsp_denied, fl_rd, fl_wr, fl_erase_page, fl_erase_all;
    wire sense_amp_oneshot_enable, read_always_enable;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] bm [0:65535];
    logic [7:0] m_lim = 8'h00, m_rdl, m_wel;
    logic m_limset = 1'b0, m_we = 1'b0;
    logic [31:0] rng = 91;

    fasg_guard i_dut (.*);
    fasg_flash_model i_flash (.*);

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic deny(logic s, logic [1:0] op, logic [15:0] a, logic [15:0] pc);
        logic sec;
        logic low;
        sec = a[15:1] == 15'h7EFF;
        low = pc >= {m_lim, 8'h00} && a < {m_lim, 8'h00};
        if (a >= 16'hFE00) return 1'b1;
        if (s && op[0] ^ op[1]) return !(sec || m_wel[a[15:13]]);
        if (s) return !(sec || m_rdl[a[15:13]]);
        if (op == `FASG_OP_FETCH) return 1'b0;
        if (op == `FASG_OP_READ) return low;
        return low || !m_we || (op == `FASG_OP_ERASE && a[15:9] == 7'h7E);
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic sfr_w(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        if (a == `FASG_ACL_ADDR && !m_limset) begin
            m_lim = d;
            m_limset = 1'b1;
        end
        if (a == `FASG_FCR_ADDR) m_we = d[0];
    endtask

    task automatic sfr_r(logic [7:0] a, logic [7:0] ex);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        `FASG_CHK("sfr_rdata", ex, sfr_rdata)
    endtask

    task automatic acc(logic s, logic [1:0] op, logic [15:0] a, logic [7:0] d, logic [15:0] pc);
        logic dn;
        logic wide;
        int k;
        dn = deny(s, op, a, pc);
        k = 0;
        while (req_ready !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        @(posedge clk_sys);
        {req_valid, req_src, req_op, req_addr, req_wdata, req_pc} <= {1'b1, s, op, a, d, pc};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        #1;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 10) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        `FASG_CHK("rsp_valid", 1'b1, rsp_valid)
        `FASG_CHK("rsp_denied", dn, rsp_denied)
        `FASG_CHK("rsp_rdata", (dn || op[0] ^ op[1]) ? 8'h00 : bm[a], rsp_rdata)
        if (!dn && op == `FASG_OP_WRITE) begin
            bm[a] = bm[a] & d;
            if (a == `FASG_WE_LOCK_ADDR) m_wel = m_wel & d;
            if (a == `FASG_RD_LOCK_ADDR) m_rdl = m_rdl & d;
        end
        if (!dn && op == `FASG_OP_ERASE) begin
            wide = s && a[15:1] == 15'h7EFF;
            for (int i = 0; i < 65024; i++) begin
                if (wide || i[15:9] == a[15:9]) bm[i] = 8'hFF;
            end
            if (a[15:9] == 7'h7E) begin
                m_wel = 8'hFF;
                m_rdl = 8'hFF;
            end
        end
    endtask

    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end

    initial begin
        for (int i = 0; i < 65536; i++) begin
            bm[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
        end
        m_rdl = init_rd_lock;
        m_wel = init_we_lock;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        sfr_r(`FASG_FCR_ADDR, 8'h80);
        sfr_r(`FASG_ACL_ADDR, 8'h00);
        sfr_r(8'hB5, 8'h00);
        `FASG_CHK("oneshot", 1'b1, sense_amp_oneshot_enable)
        acc(0, `FASG_OP_READ, 16'h0100, 8'h00, 16'hF000);
        acc(0, `FASG_OP_WRITE, 16'h0200, 8'h0F, 16'h0000);
        sfr_w(`FASG_FCR_ADDR, 8'hFF);
        sfr_r(`FASG_FCR_ADDR, 8'hC1);
        `FASG_CHK("read_always", 1'b1, read_always_enable)
        sfr_w(`FASG_ACL_ADDR, 8'h40);
        sfr_w(`FASG_ACL_ADDR, 8'h80);
        sfr_r(`FASG_ACL_ADDR, 8'h40);
        $display("test registers done");
        acc(0, `FASG_OP_WRITE, 16'h0200, 8'h0F, 16'h0000);
        acc(0, `FASG_OP_READ, 16'h3FFF, 8'h00, 16'h4000);
        acc(0, `FASG_OP_READ, 16'h4000, 8'h00, 16'h4000);
        acc(0, `FASG_OP_READ, 16'hC000, 8'h00, 16'h3FFF);
        acc(0, `FASG_OP_FETCH, 16'h0100, 8'h00, 16'h8000);
        acc(0, `FASG_OP_ERASE, 16'hFC00, 8'h00, 16'h0000);
        acc(0, `FASG_OP_READ, 16'h0010, 8'h00, 16'h0010);
        acc(0, `FASG_OP_WRITE, 16'hFE10, 8'h00, 16'h0000);
        for (int n = 0; n < 24; n++) begin
            acc(0, xs() % 4, xs(), xs(), xs());
        end
        $display("test firmware done");
        acc(1, `FASG_OP_READ, 16'h0100, 8'h00, 16'h0000);
        acc(1, `FASG_OP_READ, 16'h2100, 8'h00, 16'h0000);
        acc(1, `FASG_OP_WRITE, 16'h2100, 8'h00, 16'h0000);
        acc(1, `FASG_OP_WRITE, 16'h4100, 8'h0F, 16'h0000);
        acc(1, `FASG_OP_READ, 16'hFDFF, 8'h00, 16'h0000);
        acc(1, `FASG_OP_WRITE, 16'hFDFE, 8'h7F, 16'h0000);
        acc(1, `FASG_OP_ERASE, 16'hFC00, 8'h00, 16'h0000);
        acc(1, `FASG_OP_ERASE, 16'hFDFF, 8'h00, 16'h0000);
        acc(1, `FASG_OP_READ, 16'h0100, 8'h00, 16'h0000);
        acc(1, `FASG_OP_ERASE, 16'hFC10, 8'h00, 16'h0000);
        acc(1, `FASG_OP_READ, 16'hFC10, 8'h00, 16'h0000);
        acc(1, `FASG_OP_ERASE, 16'hFE00, 8'h00, 16'h0000);
        $display("test debug host done");
        print_verdict();
    end
endmodule
